// >>> pkg/sas_pkg.sv
// constants and types shared by the converter sequencer
package sas_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and conversion timing
  localparam int unsigned CLK_FREQ_KHZ      = 125000;
  localparam int unsigned CONV_MIN_FREQ_KHZ = 1000;
  localparam int unsigned CONV_MAX_GAP_CYC  = CLK_FREQ_KHZ / CONV_MIN_FREQ_KHZ;
  localparam int unsigned CONV_TICKS        = 32;
  localparam logic [4:0]  CNT_RST           = 5'h00;
  localparam logic [4:0]  CNT_LAST          = 5'(CONV_TICKS - 1);
  localparam logic [4:0]  ACQ_LAST          = 5'h07;
  localparam logic [1:0]  PH_RST            = 2'h0;
  localparam logic [1:0]  PH_DECIDE         = 2'h2;
  localparam logic [2:0]  BIT_MSB           = 3'h7;
  localparam logic [7:0]  TRIAL_MSB         = 8'h80;
  localparam logic [7:0]  ZERO_CODE         = 8'h00;
  localparam logic [5:0]  AGE_RST           = 6'h00;
  localparam logic [5:0]  AGE_MAX           = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [1:0]  REG_CTRL_OFS      = 2'h0;
  localparam logic [1:0]  REG_RESULT_OFS    = 2'h1;
  localparam int unsigned CTRL_DONE_BIT     = 7;
  localparam int unsigned CTRL_RC_BIT       = 6;
  localparam int unsigned CTRL_PWR_BIT      = 5;
  localparam logic [4:0]  CHAN_RST          = 5'h00;
  localparam logic [7:0]  RESULT_RST        = 8'h00;
  localparam logic [7:0]  RDATA_RST         = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // channel codes and multiplexer select
  localparam int unsigned SRC_W             = 9;
  localparam logic [4:0]  CH_EXT_LAST       = 5'h04;
  localparam logic [4:0]  CH_UPPER          = 5'h10;
  localparam logic [4:0]  CH_MID            = 5'h11;
  localparam logic [4:0]  CH_LOWER          = 5'h12;
  localparam logic [4:0]  CH_TEST           = 5'h13;
  localparam logic [8:0]  SRC_NONE          = 9'h000;
  localparam logic [8:0]  SRC_ONE           = 9'h001;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_BITS
  } sas_state_t;

endpackage : sas_pkg

// >>> core/sas_top.sv
// successive-approximation converter sequencer with register port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
module sas_top
  import sas_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  // register port
  input  wire logic [1:0]          addr_i,
  input  wire logic [7:0]          wr_data_i,
  input  wire logic                wr_en_i,
  input  wire logic                rd_en_i,
  output logic      [7:0]          rd_data_o,
  // operating modes
  input  wire logic                stop_i,
  input  wire logic                wait_i,
  input  wire logic                single_chip_i,
  // rc oscillator
  input  wire logic                rc_osc_i,
  output logic                     rc_osc_en_o,
  // analog side
  input  wire logic                cmp_i,
  output logic      [7:0]          dac_code_o,
  output logic                     sample_o,
  output logic      [sas_pkg::SRC_W-1:0] mux_sel_o,
  output logic                     cmp_en_o,
  output logic                     pump_en_o
);
  import sas_pkg::*;

  typedef struct packed {
    sas_state_t       state;
    logic [4:0]       cnt;
    logic [1:0]       ph;
    logic [2:0]       bitn;
    logic [7:0]       trial;
    logic             done_flag;
    logic             rc_sel;
    logic             pwr_on;
    logic [4:0]       chan;
    logic [7:0]       result;
    logic [7:0]       rd_data;
    logic             sample;
    logic [SRC_W-1:0] mux_sel;
    logic             cmp_en;
    logic             pump_en;
    logic             rc_en;
    logic             rc_s1;
    logic             rc_s2;
    logic             rc_s3;
    logic             rc_lvl;
    logic [5:0]       smp_age;
  } sas_st_t;

  sas_st_t st_r;
  sas_st_t st_nxt;

  logic       ctrl_wr;
  logic       res_rd;
  logic       rc_edge;
  logic       tick;
  logic       done_ev;
  logic [7:0] trial_dec;
  logic [7:0] final_code;

  ////////////////////////////////////////////////////////////////////////////
  // channel code to one-hot multiplexer select
  function automatic logic [SRC_W-1:0] chan_dec(input logic [4:0] ch);
    logic [SRC_W-1:0] sel;
    sel = SRC_NONE;
    if (ch <= CH_EXT_LAST)
    begin
      sel = SRC_ONE << ch;
    end
    else if (ch >= CH_UPPER && ch <= CH_TEST)
    begin
      sel = SRC_ONE << (ch - CH_UPPER + 5'(CH_EXT_LAST + 5'h01));
    end
    return sel;
  endfunction : chan_dec

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt  = st_r;
    ctrl_wr = wr_en_i && (addr_i == REG_CTRL_OFS);
    res_rd  = rd_en_i && (addr_i == REG_RESULT_OFS);

    // rc clock pin: three stages, edge once stages two and three agree
    st_nxt.rc_s1 = rc_osc_i;
    st_nxt.rc_s2 = st_r.rc_s1;
    st_nxt.rc_s3 = st_r.rc_s2;
    if (st_r.rc_s2 == st_r.rc_s3)
    begin
      st_nxt.rc_lvl = st_r.rc_s3;
    end
    rc_edge = (st_r.rc_s2 == st_r.rc_s3) && st_r.rc_s3 && !st_r.rc_lvl;
    tick    = st_r.rc_sel ? rc_edge : 1'b1;

    // one comparison step of the search
    trial_dec = st_r.trial;
    if (!cmp_i)
    begin
      trial_dec[st_r.bitn] = 1'b0;
    end
    if (st_r.bitn != 3'h0)
    begin
      trial_dec[st_r.bitn - 3'h1] = 1'b1;
    end
    final_code = (single_chip_i && st_r.chan == CH_TEST) ? ZERO_CODE
                                                         : trial_dec;

    done_ev = (st_r.state == ST_BITS) && tick && (st_r.cnt == CNT_LAST)
              && (st_r.ph == PH_DECIDE) && !stop_i && !ctrl_wr;

    st_nxt.sample = 1'b0;
    case (st_r.state)
      ST_IDLE:
      begin
        st_nxt.cnt = CNT_RST;
      end
      ST_ACQ:
      begin
        if (tick)
        begin
          st_nxt.sample = (st_r.cnt == CNT_RST);
          st_nxt.cnt    = st_r.cnt + 5'h01;
          if (st_r.cnt == ACQ_LAST)
          begin
            st_nxt.state = ST_BITS;
            st_nxt.trial = TRIAL_MSB;
            st_nxt.bitn  = BIT_MSB;
            st_nxt.ph    = PH_RST;
          end
        end
      end
      ST_BITS:
      begin
        if (tick)
        begin
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.ph == PH_DECIDE)
          begin
            st_nxt.trial = trial_dec;
            st_nxt.bitn  = st_r.bitn - 3'h1;
            st_nxt.ph    = PH_RST;
          end
          else
          begin
            st_nxt.ph = st_r.ph + 2'h1;
          end
          if (st_r.cnt == CNT_LAST)
          begin
            st_nxt.state = ST_ACQ;
            st_nxt.trial = ZERO_CODE;
            st_nxt.cnt   = CNT_RST;
          end
        end
      end
      default:
      begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // completion: result overwritten, flag set wins over a result-read clear; a control write blocks completion
    if (done_ev)
    begin
      st_nxt.result = final_code;
    end
    st_nxt.done_flag = done_ev
                       || (st_r.done_flag && !(ctrl_wr || res_rd));

    // control write restarts the sequence, or idles it when the power bit is clear
    if (ctrl_wr)
    begin
      st_nxt.rc_sel = wr_data_i[CTRL_RC_BIT];
      st_nxt.pwr_on = wr_data_i[CTRL_PWR_BIT];
      st_nxt.chan   = wr_data_i[4:0];
      st_nxt.state  = wr_data_i[CTRL_PWR_BIT] ? ST_ACQ : ST_IDLE;
      st_nxt.cnt    = CNT_RST;
      st_nxt.ph     = PH_RST;
      st_nxt.trial  = ZERO_CODE;
      st_nxt.sample = 1'b0;
    end

    // stop aborts the conversion, keeps registers, restarts on exit
    if (stop_i && st_nxt.state != ST_IDLE)
    begin
      st_nxt.state  = ST_ACQ;
      st_nxt.cnt    = CNT_RST;
      st_nxt.trial  = ZERO_CODE;
      st_nxt.sample = 1'b0;
    end

    // register read data, valid only in the cycle after the strobe
    st_nxt.rd_data = RDATA_RST;
    if (rd_en_i)
    begin
      case (addr_i)
        REG_CTRL_OFS:
        begin
          st_nxt.rd_data = {st_r.done_flag, st_r.rc_sel, st_r.pwr_on, st_r.chan};
        end
        REG_RESULT_OFS:
        begin
          st_nxt.rd_data = st_r.result;
        end
        default:
        begin
          st_nxt.rd_data = RDATA_RST;
        end
      endcase
    end

    // analog enables
    st_nxt.mux_sel = chan_dec(st_nxt.chan);
    st_nxt.cmp_en  = st_nxt.pwr_on && !stop_i;
    st_nxt.pump_en = st_nxt.pwr_on && !stop_i;
    st_nxt.rc_en   = st_nxt.rc_sel && !stop_i;

    // cycles since the last sample pulse
    if (st_r.sample)
    begin
      st_nxt.smp_age = 6'h01;
    end
    else if (st_r.smp_age != AGE_MAX)
    begin
      st_nxt.smp_age = st_r.smp_age + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '{state: ST_IDLE, cnt: CNT_RST, ph: PH_RST, bitn: BIT_MSB,
                trial: ZERO_CODE, chan: CHAN_RST, result: RESULT_RST,
                rd_data: RDATA_RST, mux_sel: SRC_ONE, smp_age: AGE_RST,
                default: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o   = st_r.rd_data;
  assign dac_code_o  = st_r.trial;
  assign sample_o    = st_r.sample;
  assign mux_sel_o   = st_r.mux_sel;
  assign cmp_en_o    = st_r.cmp_en;
  assign pump_en_o   = st_r.pump_en;
  assign rc_osc_en_o = st_r.rc_en;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  conv_len_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(st_r.done_flag) && !st_r.rc_sel |-> st_r.smp_age == 6'(CONV_TICKS - 1))
    else $error("bus-clock conversion not 32 cycles");

  repeat_conv_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    done_ev && !st_r.rc_sel ##1 (!wr_en_i && !stop_i)[*2] |-> sample_o)
    else $error("continuous conversion did not restart");

  flag_set_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    done_ev |=> st_r.done_flag && st_r.result == $past(final_code))
    else $error("done flag or result missing after conversion");

  result_change_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $changed(st_r.result) |-> st_r.done_flag && $past(st_r.state) == ST_BITS)
    else $error("result changed without completion");

  flag_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (ctrl_wr || res_rd) && !done_ev |=> !st_r.done_flag)
    else $error("done flag not cleared by access");

  test_chan_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    done_ev && single_chip_i && st_r.chan == CH_TEST |=> st_r.result == ZERO_CODE)
    else $error("test channel not zero in single-chip mode");

  stop_off_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    stop_i |=> !cmp_en_o && !pump_en_o && !sample_o && $stable(st_r.result))
    else $error("stop mode left analog on or changed result");

  stop_rc_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    stop_i && !wr_en_i |=> !rc_osc_en_o && st_r.pwr_on == $past(st_r.pwr_on))
    else $error("stop mode left rc running or dropped power bit");

  rc_tick_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    st_r.rc_sel && !rc_edge && !wr_en_i && !stop_i |=> $stable(st_r.cnt))
    else $error("conversion advanced without rc edge");

  wait_keep_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    wait_i && st_r.done_flag && !wr_en_i && !rd_en_i |=> st_r.done_flag)
    else $error("done flag lost in wait mode");

  chan_sel_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    st_r.chan == CH_UPPER |-> mux_sel_o == 9'h020)
    else $error("bad channel select");

  sel_onehot_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $onehot0(mux_sel_o))
    else $error("channel select not one-hot");

endmodule : sas_top

// >>> verif/sas_analog_model.sv
// behavioural analog side: input mux, sample-and-hold, comparator
`timescale 1ns/10ps
module sas_analog_model
#(
  parameter logic [8:0] TEST_LVL = 9'h05A,
  parameter logic [8:0] MID_LVL  = 9'h080
)(
  // clock
  input  wire logic        ref_clk_i,
  // converter side
  input  wire logic        sample_i,
  input  wire logic [8:0]  mux_sel_i,
  input  wire logic [7:0]  dac_code_i,
  input  wire logic        cmp_en_i,
  // pin levels, 9 bits each so a pin can sit above the upper reference
  input  wire logic [44:0] pin_lvl_i,
  output logic             cmp_o
);
  logic [8:0] held_r;
  logic [8:0] sel_lvl;
  logic       junk_r = 1'b0;
  always_comb
  begin
    sel_lvl = 9'h000;
    for (int i = 0; i < 5; i++)
      if (mux_sel_i[i]) sel_lvl = pin_lvl_i[i*9 +: 9];
    if (mux_sel_i[5]) sel_lvl = 9'h0FF;
    if (mux_sel_i[6]) sel_lvl = MID_LVL;
    if (mux_sel_i[7]) sel_lvl = 9'h000;
    if (mux_sel_i[8]) sel_lvl = TEST_LVL;
  end
  ////////////////////////////////////////////////////////////////////////////
  // hold once per conversion; disabled comparator gives garbage
  always @(posedge ref_clk_i)
  begin
    junk_r <= ~junk_r;
    if (sample_i) held_r <= sel_lvl;
  end
  assign cmp_o = cmp_en_i ? (held_r >= {1'b0, dac_code_i}) : junk_r;
endmodule : sas_analog_model

// >>> verif/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb;
  import sas_pkg::*;
  typedef struct { logic [4:0] ch; logic [7:0] res; logic [8:0] mux; } sas_row_t;
  localparam int PWR_SETTLE_CYC = 20;
  localparam int RC_SETTLE_CYC  = 200;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic [1:0]  addr      = 2'h0;
  logic [7:0]  wr_data   = 8'h00;
  logic        wr_en     = 1'b0;
  logic        rd_en     = 1'b0;
  logic        stop      = 1'b0;
  logic        wait_m    = 1'b0;
  logic        chip      = 1'b0;
  logic        rc_osc    = 1'b0;
  logic [44:0] pin_lvl   = {9'h0AA, 9'h055, 9'h1FF, 9'h0FF, 9'h000};
  logic [7:0]  rd_data;
  logic [7:0]  dac;
  logic [8:0]  mux;
  logic        rc_en;
  logic        smp;
  logic        cmp_en;
  logic        pump_en;
  logic        cmp;
  logic [7:0]  v;
  int          n;
  int          miscompares = 0;
  int          checked     = 0;
  sas_row_t    rows [9] = '{'{5'h00, 8'h00, 9'h001}, '{5'h01, 8'hFF, 9'h002},
    '{5'h02, 8'hFF, 9'h004}, '{5'h03, 8'h55, 9'h008}, '{5'h04, 8'hAA, 9'h010},
    '{5'h10, 8'hFF, 9'h020}, '{5'h11, 8'h80, 9'h040}, '{5'h12, 8'h00, 9'h080},
    '{5'h13, 8'h5A, 9'h100}};
  always #4 ref_clk_i = ~ref_clk_i;
  always
  begin
    #336;
    rc_osc = (rc_en === 1'b1) ? ~rc_osc : 1'b0;
  end
  sas_top dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr),
    .wr_data_i(wr_data), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .stop_i(stop), .wait_i(wait_m), .single_chip_i(chip), .rc_osc_i(rc_osc),
    .rc_osc_en_o(rc_en), .cmp_i(cmp), .dac_code_o(dac), .sample_o(smp),
    .mux_sel_o(mux), .cmp_en_o(cmp_en), .pump_en_o(pump_en));
  sas_analog_model model_u (.ref_clk_i(ref_clk_i), .sample_i(smp), .mux_sel_i(mux),
    .dac_code_i(dac), .cmp_en_i(cmp_en), .pin_lvl_i(pin_lvl), .cmp_o(cmp));
  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk_i);
    wr_en   <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk_i);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic wait_done(input int bound);
    n = 0;
    v = 8'h00;
    while (v[CTRL_DONE_BIT] !== 1'b1)
    begin
      rd(REG_CTRL_OFS, v);
      n++;
      if (n > bound)
      begin
        chk("done wait", 9'h001, 9'h000);
        give_verdict();
      end
    end
  endtask : wait_done
  task automatic wait_smp();
    n = 0;
    do
    begin
      @(negedge ref_clk_i);
      n++;
    end while (smp !== 1'b1 && n < 200);
    if (smp !== 1'b1)
    begin
      chk("sample wait", 9'h001, 9'h000);
      give_verdict();
    end
  endtask : wait_smp
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1 chk("mux reset", 9'h001, mux);
    chk("cmp en reset", 9'h000, {cmp_en, pump_en, rc_en, smp});
    rd(REG_CTRL_OFS, v);
    chk("ctrl reset", 9'h000, v);
    rd(REG_RESULT_OFS, v);
    chk("result reset", 9'h000, v);
    wr(2'h2, 8'hFF);
    rd(2'h2, v);
    chk("unmapped", 9'h000, v);
    rd(REG_CTRL_OFS, v);
    chk("ctrl after unmapped", 9'h000, v);
    $display("test reset done");
    wr(REG_CTRL_OFS, 8'h20);
    repeat (PWR_SETTLE_CYC) @(posedge ref_clk_i);
    foreach (rows[i])
    begin
      wr(REG_CTRL_OFS, {3'h1, rows[i].ch});
      repeat (3) @(posedge ref_clk_i);
      #1 chk("mux", rows[i].mux, mux);
      wait_done(100);
      rd(REG_RESULT_OFS, v);
      chk("result", rows[i].res, v);
      rd(REG_CTRL_OFS, v);
      chk("done after read", 9'h000, v[CTRL_DONE_BIT]);
      $display("test row %0d done", i);
    end
    wr(REG_CTRL_OFS, 8'h25);
    repeat (3) @(posedge ref_clk_i);
    #1 chk("mux unused", 9'h000, mux);
    chip <= 1'b1;
    wr(REG_CTRL_OFS, 8'h33);
    wait_done(100);
    rd(REG_RESULT_OFS, v);
    chk("test channel", 9'h000, v);
    chip <= 1'b0;
    $display("test channels done");
    wr(REG_CTRL_OFS, 8'h23);
    wait_smp();
    wait_smp();
    chk("sample period", 9'd32, n);
    pin_lvl[27 +: 9] <= 9'h033;
    wait_smp();
    wait_smp();
    repeat (40) @(posedge ref_clk_i);
    rd(REG_RESULT_OFS, v);
    chk("overwrite", 9'h033, v);
    wait_done(100);
    wr(REG_CTRL_OFS, 8'h23);
    rd(REG_CTRL_OFS, v);
    chk("ctrl after write", 9'h023, v);
    $display("test continuous done");
    wait_m <= 1'b1;
    wr(REG_CTRL_OFS, 8'h63);
    repeat (RC_SETTLE_CYC) @(posedge ref_clk_i);
    #1 chk("rc enable", 9'h001, rc_en);
    rd(REG_RESULT_OFS, v);
    wait_done(3000);
    rd(REG_RESULT_OFS, v);
    chk("rc result", 9'h033, v);
    $display("test rc done");
    stop <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk("stop enables", 9'h000, {cmp_en, pump_en, rc_en});
    rd(REG_RESULT_OFS, v);
    chk("stop result", 9'h033, v);
    repeat (50) @(posedge ref_clk_i);
    rd(REG_CTRL_OFS, v);
    chk("stop ctrl", 9'h063, v);
    stop   <= 1'b0;
    wait_m <= 1'b0;
    wr(REG_CTRL_OFS, 8'h00);
    $display("test stop done");
    wr(REG_CTRL_OFS, 8'h23);
    repeat (8) @(posedge ref_clk_i);
    #1 chk("dac first trial", 9'h080, {1'b0, dac});
    nrst_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1 chk("mux mid reset", 9'h001, mux);
    chk("dac mid reset", 9'h000, {1'b0, dac});
    chk("enables mid reset", 9'h000, {cmp_en, pump_en, rc_en, smp});
    rd(REG_CTRL_OFS, v);
    chk("ctrl mid reset", 9'h000, v);
    rd(REG_RESULT_OFS, v);
    chk("result mid reset", 9'h000, v);
    $display("test mid reset done");
    give_verdict();
  end
endmodule : tb
